/* hdl/dppc_pkg.sv */
// Constants, register map and carrier types of the dual port pin control block
// Operation
// - Port4 direction bit one means output
// - Port4 direction/data apply only in I/O function
// - Port4 direction write-only, reads ones, resets zero
// - Port4 data read: output data, input pin
// - Port4 data read/write, resets zero
// - Bit7 mode one makes trigger input
// - Bit6 follows compare B when enabled
// - Bit5 follows compare A when enabled
// - Bits4-1 always feed capture inputs D-A
// - Bit0 mode one drives wide PWM
// - Pins float in reset, standby, watch
// - Port6 mode bit one selects realtime output
// - Aux bit7 one makes timer B event
// - Aux bit6 chooses event edge polarity
// - Aux register only bits 7,6; reset 3F
// - Port6 I/O direction one means output
// - Port6 direction write-only, reads ones, resets zero
// - Trigger edge register resets to FC
// - Port6 slave copies hidden, reset zero
// - Trigger loads slaves; slave direction gates drive
// - I/O mode data writes also load slave
// - Edge field: off, rise, fall, both
// - Source bit picks external pin or head-switch
package dppc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] DPPC_OFS_P6_DATA   = 16'hFFC6;
  localparam logic [15:0] DPPC_OFS_P6_DIR    = 16'hFFD6;
  localparam logic [15:0] DPPC_OFS_P6_AUX    = 16'hFFD9;
  localparam logic [15:0] DPPC_OFS_P6_FUNC   = 16'hFFDD;
  localparam logic [15:0] DPPC_OFS_RT_EDGE   = 16'hFFE4;
  localparam logic [15:0] DPPC_OFS_RT_SRC    = 16'hFFE5;
  localparam logic [15:0] DPPC_OFS_P4_DATA   = 16'hFFC4;
  localparam logic [15:0] DPPC_OFS_P4_DIR    = 16'hFFD4;
  localparam logic [15:0] DPPC_OFS_P4_FUNC   = 16'hFFDB;
  localparam logic [15:0] DPPC_OFS_TIMER_OUT = 16'hFFF0;
  localparam logic [15:0] DPPC_OFS_POWER     = 16'hFFF1;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] DPPC_RST_ZERO      = 8'h00;
  localparam logic [7:0] DPPC_RST_P4_FUNC   = 8'h7E;
  localparam logic [7:0] DPPC_RST_P6_AUX    = 8'h3F;
  localparam logic [7:0] DPPC_RST_RT_EDGE   = 8'hFC;
  localparam logic [7:0] DPPC_RD_ONES       = 8'hFF;
  localparam logic [7:0] DPPC_MSK_P4_FUNC   = 8'h81;
  localparam logic [7:0] DPPC_MSK_P6_AUX    = 8'hC0;
  localparam logic [7:0] DPPC_MSK_RT_EDGE   = 8'h03;
  localparam logic [7:0] DPPC_MSK_TIMER_OUT = 8'h03;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DPPC_BIT_TRIG_PIN  = 7;
  localparam int DPPC_BIT_CMP_B     = 6;
  localparam int DPPC_BIT_CMP_A     = 5;
  localparam int DPPC_BIT_PWM_PIN   = 0;
  localparam int DPPC_BIT_EVT_PIN   = 7;
  localparam int DPPC_BIT_EVT_EDGE  = 6;
  localparam int DPPC_BIT_OE_A      = 0;
  localparam int DPPC_BIT_OE_B      = 1;

  // ----------------------------------------
  // Trigger edge codes and power modes
  // ----------------------------------------
  localparam logic [1:0] DPPC_EDGE_OFF  = 2'h0;
  localparam logic [1:0] DPPC_EDGE_RISE = 2'h1;
  localparam logic [1:0] DPPC_EDGE_FALL = 2'h2;
  localparam logic [1:0] DPPC_EDGE_BOTH = 2'h3;

  typedef enum logic [2:0] {
    DPPC_PWR_ACTIVE    = 3'h0,
    DPPC_PWR_SLEEP     = 3'h1,
    DPPC_PWR_STANDBY   = 3'h2,
    DPPC_PWR_WATCH     = 3'h3,
    DPPC_PWR_SUBACTIVE = 3'h4,
    DPPC_PWR_SUBSLEEP  = 3'h5
  } dppc_power_t;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } dppc_bus_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dppc_pin_drive_t;

  typedef struct packed {
    logic       compare_out_a;
    logic       compare_out_b;
    logic       wide_pwm_out;
    logic       head_switch_timing;
  } dppc_periph_in_t;

  typedef struct packed {
    logic [3:0] capture_in;
    logic       realtime_trigger_in;
    logic       timer_b_event_in;
    logic       event_rising;
    logic       converter_start_trigger;
  } dppc_periph_out_t;

endpackage

/* hdl/dppc_top.sv */
// Dual port pin control: register file, pin muxing and realtime output
`timescale 1ns/1ps
module dppc_top (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire dppc_pkg::dppc_bus_req_t   i_bus,
  output logic [7:0]                     o_rdata,
  input  wire dppc_pkg::dppc_periph_in_t i_periph,
  output dppc_pkg::dppc_periph_out_t     o_periph,
  input  wire logic [7:0]                i_p4_pin,
  output dppc_pkg::dppc_pin_drive_t      o_p4,
  input  wire logic [7:0]                i_p6_pin,
  output dppc_pkg::dppc_pin_drive_t      o_p6
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Mixed read of a data port: stored value on outputs, pin on inputs
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] pin);
    port_read = (dir & dat) | (~dir & pin);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]            p4_dir_q;
  logic [7:0]            p4_data_q;
  logic [7:0]            p4_func_q;
  logic [7:0]            p6_dir_q;
  logic [7:0]            p6_data_q;
  logic [7:0]            p6_func_q;
  logic [7:0]            p6_aux_q;
  logic [7:0]            rt_edge_q;
  logic [7:0]            rt_src_q;
  logic [7:0]            p6_dir_slave_q;
  logic [7:0]            p6_data_slave_q;
  logic [7:0]            timer_out_q;
  dppc_pkg::dppc_power_t power_q;
  dppc_pkg::dppc_power_t power_d;
  dppc_pkg::dppc_pin_drive_t p4_hold_q;
  dppc_pkg::dppc_pin_drive_t p6_hold_q;
  logic [7:0]            rdata_q;
  logic                  trg_ext_q;
  logic [7:0]            p4_live_q;
  logic [7:0]            p6_live_q;
  logic [7:0]            p4_s1_q, p4_s2_q, p4_s3_q;
  logic [7:0]            p6_s1_q, p6_s2_q, p6_s3_q;
  logic                  hsw_q;

  logic wr_hit;
  assign wr_hit = i_bus.wr;

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      p4_s1_q   <= 8'h00;
      p4_s2_q   <= 8'h00;
      p4_s3_q   <= 8'h00;
      p6_s1_q   <= 8'h00;
      p6_s2_q   <= 8'h00;
      p6_s3_q   <= 8'h00;
      p4_live_q <= 8'h00;
      p6_live_q <= 8'h00;
    end else begin
      p4_s1_q   <= i_p4_pin;
      p4_s2_q   <= p4_s1_q;
      p4_s3_q   <= p4_s2_q;
      p6_s1_q   <= i_p6_pin;
      p6_s2_q   <= p6_s1_q;
      p6_s3_q   <= p6_s2_q;
      p4_live_q <= (p4_s2_q & p4_s3_q) | (p4_live_q & (p4_s2_q | p4_s3_q));
      p6_live_q <= (p6_s2_q & p6_s3_q) | (p6_live_q & (p6_s2_q | p6_s3_q));
    end
  end

  // ----------------------------------------
  // Port 4 registers
  // ----------------------------------------
  // Direction, data and function select of the first port
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      p4_dir_q  <= dppc_pkg::DPPC_RST_ZERO;
      p4_data_q <= dppc_pkg::DPPC_RST_ZERO;
      p4_func_q <= dppc_pkg::DPPC_RST_P4_FUNC;
    end else if (wr_hit) begin
      if (i_bus.addr == dppc_pkg::DPPC_OFS_P4_DIR) begin
        p4_dir_q <= i_bus.wdata;
      end
      if (i_bus.addr == dppc_pkg::DPPC_OFS_P4_DATA) begin
        p4_data_q <= i_bus.wdata;
      end
      if (i_bus.addr == dppc_pkg::DPPC_OFS_P4_FUNC) begin
        // Reserved bits stay one
        p4_func_q <= (i_bus.wdata & dppc_pkg::DPPC_MSK_P4_FUNC) | ~dppc_pkg::DPPC_MSK_P4_FUNC;
      end
    end
  end

  // Timer compare enables and power mode, held locally
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      timer_out_q <= dppc_pkg::DPPC_RST_ZERO;
      power_q     <= dppc_pkg::DPPC_PWR_ACTIVE;
    end else if (wr_hit) begin
      if (i_bus.addr == dppc_pkg::DPPC_OFS_TIMER_OUT) begin
        timer_out_q <= i_bus.wdata & dppc_pkg::DPPC_MSK_TIMER_OUT;
      end
      if (i_bus.addr == dppc_pkg::DPPC_OFS_POWER) begin
        power_q <= power_d;
      end
    end
  end

  // Unknown power codes fall back to active
  always_comb begin
    unique case (i_bus.wdata[2:0])
      3'h1:    power_d = dppc_pkg::DPPC_PWR_SLEEP;
      3'h2:    power_d = dppc_pkg::DPPC_PWR_STANDBY;
      3'h3:    power_d = dppc_pkg::DPPC_PWR_WATCH;
      3'h4:    power_d = dppc_pkg::DPPC_PWR_SUBACTIVE;
      3'h5:    power_d = dppc_pkg::DPPC_PWR_SUBSLEEP;
      default: power_d = dppc_pkg::DPPC_PWR_ACTIVE;
    endcase
  end

  // ----------------------------------------
  // Port 6 registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      p6_dir_q  <= dppc_pkg::DPPC_RST_ZERO;
      p6_data_q <= dppc_pkg::DPPC_RST_ZERO;
      p6_func_q <= dppc_pkg::DPPC_RST_ZERO;
      p6_aux_q  <= dppc_pkg::DPPC_RST_P6_AUX;
      rt_edge_q <= dppc_pkg::DPPC_RST_RT_EDGE;
      rt_src_q  <= dppc_pkg::DPPC_RST_ZERO;
    end else if (wr_hit) begin
      unique case (i_bus.addr)
        dppc_pkg::DPPC_OFS_P6_DIR:  p6_dir_q  <= i_bus.wdata;
        dppc_pkg::DPPC_OFS_P6_DATA: p6_data_q <= i_bus.wdata;
        dppc_pkg::DPPC_OFS_P6_FUNC: p6_func_q <= i_bus.wdata;
        dppc_pkg::DPPC_OFS_P6_AUX:
          p6_aux_q <= (i_bus.wdata & dppc_pkg::DPPC_MSK_P6_AUX) | ~dppc_pkg::DPPC_MSK_P6_AUX;
        dppc_pkg::DPPC_OFS_RT_EDGE:
          rt_edge_q <= (i_bus.wdata & dppc_pkg::DPPC_MSK_RT_EDGE) | ~dppc_pkg::DPPC_MSK_RT_EDGE;
        dppc_pkg::DPPC_OFS_RT_SRC:  rt_src_q  <= i_bus.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Realtime trigger detection
  // ----------------------------------------
  // External trigger from the synchronised bit-7 pin; head switch is same-clock
  logic ext_now;
  logic ext_rise, ext_fall, hsw_rise, hsw_fall;
  logic [1:0] edge_sel;
  logic [7:0] trig_bits;
  assign ext_now  = p4_live_q[dppc_pkg::DPPC_BIT_TRIG_PIN];
  assign edge_sel = rt_edge_q[1:0];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      trg_ext_q <= 1'b0;
      hsw_q     <= 1'b0;
    end else begin
      trg_ext_q <= ext_now;
      hsw_q     <= i_periph.head_switch_timing;
    end
  end

  assign ext_rise = ext_now & ~trg_ext_q;
  assign ext_fall = ~ext_now & trg_ext_q;
  assign hsw_rise = i_periph.head_switch_timing & ~hsw_q;
  assign hsw_fall = ~i_periph.head_switch_timing & hsw_q;

  // Edge field decode; trigger pin counts whatever the port 4 bit-7 function select
  logic ext_hit, hsw_hit;
  always_comb begin
    unique case (edge_sel)
      dppc_pkg::DPPC_EDGE_RISE: begin
        ext_hit = ext_rise;
        hsw_hit = hsw_rise;
      end
      dppc_pkg::DPPC_EDGE_FALL: begin
        ext_hit = ext_fall;
        hsw_hit = hsw_fall;
      end
      dppc_pkg::DPPC_EDGE_BOTH: begin
        ext_hit = ext_rise | ext_fall;
        hsw_hit = hsw_rise | hsw_fall;
      end
      default: begin
        ext_hit = 1'b0;
        hsw_hit = 1'b0;
      end
    endcase
  end

  // Per-bit source choice
  assign trig_bits = (rt_src_q & {8{hsw_hit}}) | (~rt_src_q & {8{ext_hit}});

  // ----------------------------------------
  // Port 6 slave copies
  // ----------------------------------------
  // In I/O mode the slaves shadow the masters, so they act as one register
  logic [7:0] p6_wr_data;
  logic [7:0] p6_wr_dir;
  assign p6_wr_data = {8{wr_hit && i_bus.addr == dppc_pkg::DPPC_OFS_P6_DATA}};
  assign p6_wr_dir  = {8{wr_hit && i_bus.addr == dppc_pkg::DPPC_OFS_P6_DIR}};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      p6_data_slave_q <= dppc_pkg::DPPC_RST_ZERO;
      p6_dir_slave_q  <= dppc_pkg::DPPC_RST_ZERO;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (p6_func_q[i] && trig_bits[i]) begin
          p6_data_slave_q[i] <= p6_data_q[i];
          p6_dir_slave_q[i]  <= p6_dir_q[i];
        end else if (!p6_func_q[i]) begin
          if (p6_wr_data[i]) begin
            p6_data_slave_q[i] <= i_bus.wdata[i];
          end
          if (p6_wr_dir[i]) begin
            p6_dir_slave_q[i] <= i_bus.wdata[i];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [7:0] p4_out, p4_oe, p6_out, p6_oe;
  logic [7:0] p4_io;
  logic       float_pins, hold_pins;

  // I/O function per bit of the first port
  always_comb begin
    p4_io = 8'hFF;
    p4_io[dppc_pkg::DPPC_BIT_TRIG_PIN] = ~p4_func_q[dppc_pkg::DPPC_BIT_TRIG_PIN];
    p4_io[dppc_pkg::DPPC_BIT_CMP_B]    = ~timer_out_q[dppc_pkg::DPPC_BIT_OE_B];
    p4_io[dppc_pkg::DPPC_BIT_CMP_A]    = ~timer_out_q[dppc_pkg::DPPC_BIT_OE_A];
    p4_io[dppc_pkg::DPPC_BIT_PWM_PIN]  = ~p4_func_q[dppc_pkg::DPPC_BIT_PWM_PIN];
    p4_out = p4_data_q;
    p4_oe  = p4_dir_q & p4_io;
    p4_out[dppc_pkg::DPPC_BIT_CMP_B]   = p4_io[dppc_pkg::DPPC_BIT_CMP_B] ?
                                         p4_data_q[dppc_pkg::DPPC_BIT_CMP_B] : i_periph.compare_out_b;
    p4_out[dppc_pkg::DPPC_BIT_CMP_A]   = p4_io[dppc_pkg::DPPC_BIT_CMP_A] ?
                                         p4_data_q[dppc_pkg::DPPC_BIT_CMP_A] : i_periph.compare_out_a;
    p4_out[dppc_pkg::DPPC_BIT_PWM_PIN] = p4_io[dppc_pkg::DPPC_BIT_PWM_PIN] ?
                                         p4_data_q[dppc_pkg::DPPC_BIT_PWM_PIN] : i_periph.wide_pwm_out;
    p4_oe[dppc_pkg::DPPC_BIT_CMP_B]   = p4_oe[dppc_pkg::DPPC_BIT_CMP_B] | ~p4_io[dppc_pkg::DPPC_BIT_CMP_B];
    p4_oe[dppc_pkg::DPPC_BIT_CMP_A]   = p4_oe[dppc_pkg::DPPC_BIT_CMP_A] | ~p4_io[dppc_pkg::DPPC_BIT_CMP_A];
    p4_oe[dppc_pkg::DPPC_BIT_PWM_PIN] = p4_oe[dppc_pkg::DPPC_BIT_PWM_PIN] | ~p4_io[dppc_pkg::DPPC_BIT_PWM_PIN];
  end

  // Second port: I/O mode uses masters, realtime mode uses slaves
  logic evt_pin;
  always_comb begin
    p6_out = (p6_func_q & p6_data_slave_q) | (~p6_func_q & p6_data_q);
    p6_oe  = (p6_func_q & p6_dir_slave_q) | (~p6_func_q & p6_dir_q);
    p6_oe[dppc_pkg::DPPC_BIT_EVT_PIN] &= ~evt_pin;
  end
  assign evt_pin = p6_aux_q[dppc_pkg::DPPC_BIT_EVT_PIN];

  // Power-mode states of the pins
  assign float_pins = (power_q == dppc_pkg::DPPC_PWR_STANDBY) || (power_q == dppc_pkg::DPPC_PWR_WATCH);
  assign hold_pins  = (power_q == dppc_pkg::DPPC_PWR_SLEEP) || (power_q == dppc_pkg::DPPC_PWR_SUBSLEEP);

  // Registered pin drive; float in reset, freeze in sleep modes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      p4_hold_q <= '0;
      p6_hold_q <= '0;
    end else if (float_pins) begin
      p4_hold_q.oe <= 8'h00;
      p6_hold_q.oe <= 8'h00;
    end else if (!hold_pins) begin
      p4_hold_q.out <= p4_out;
      p4_hold_q.oe  <= p4_oe;
      p6_hold_q.out <= p6_out;
      p6_hold_q.oe  <= p6_oe;
    end
  end

  // Reset forces float combinationally too, so no edge is needed
  always_comb begin
    o_p4 = p4_hold_q;
    o_p6 = p6_hold_q;
    if (i_sys_rst) begin
      o_p4.oe = 8'h00;
      o_p6.oe = 8'h00;
    end
  end

  // ----------------------------------------
  // Peripheral inputs
  // ----------------------------------------
  always_comb begin
    o_periph.capture_in          = p4_live_q[4:1];
    o_periph.realtime_trigger_in = ext_now & p4_func_q[dppc_pkg::DPPC_BIT_TRIG_PIN];
    o_periph.timer_b_event_in    = evt_pin & p6_live_q[7];
    o_periph.event_rising        = p6_aux_q[dppc_pkg::DPPC_BIT_EVT_EDGE];
    o_periph.converter_start_trigger = p6_live_q[6];
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Data appears the cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 8'h00;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        dppc_pkg::DPPC_OFS_P4_DIR:    rdata_q <= dppc_pkg::DPPC_RD_ONES;
        dppc_pkg::DPPC_OFS_P4_DATA:   rdata_q <= port_read(p4_dir_q, p4_data_q, p4_live_q);
        dppc_pkg::DPPC_OFS_P4_FUNC:   rdata_q <= p4_func_q;
        dppc_pkg::DPPC_OFS_P6_DIR:    rdata_q <= dppc_pkg::DPPC_RD_ONES;
        dppc_pkg::DPPC_OFS_P6_DATA:   rdata_q <= (p6_func_q & p6_data_q) |
                                                 (~p6_func_q & port_read(p6_dir_q, p6_data_q, p6_live_q));
        dppc_pkg::DPPC_OFS_P6_FUNC:   rdata_q <= p6_func_q;
        dppc_pkg::DPPC_OFS_P6_AUX:    rdata_q <= p6_aux_q;
        dppc_pkg::DPPC_OFS_RT_EDGE:   rdata_q <= rt_edge_q;
        dppc_pkg::DPPC_OFS_RT_SRC:    rdata_q <= rt_src_q;
        dppc_pkg::DPPC_OFS_TIMER_OUT: rdata_q <= timer_out_q;
        dppc_pkg::DPPC_OFS_POWER:     rdata_q <= {5'h00, power_q};
        default:                      rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;

endmodule

/* bench/dppc_assertions.sv */
// Port-level assertions for the dual port pin control block
`timescale 1ns/1ps
module dppc_checker (
  input wire logic                       i_clk,
  input wire logic                       i_sys_rst,
  input wire dppc_pkg::dppc_bus_req_t    i_bus,
  input wire logic [7:0]                 o_rdata,
  input wire dppc_pkg::dppc_periph_in_t  i_periph,
  input wire dppc_pkg::dppc_periph_out_t o_periph,
  input wire logic [7:0]                 i_p4_pin,
  input wire dppc_pkg::dppc_pin_drive_t  o_p4,
  input wire dppc_pkg::dppc_pin_drive_t  o_p6
);
  // ----------------------------------------
  // Shadows of bus-written controls
  // ----------------------------------------
  logic       en_a_q;
  logic       pwm_q;
  logic [2:0] pwr_q;
  logic       run;
  logic       park;
  logic       nap;

  // Registers are hidden, so mirror the few that gate pin drive
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      en_a_q <= 1'b0;
      pwm_q  <= 1'b0;
      pwr_q  <= 3'h0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == dppc_pkg::DPPC_OFS_TIMER_OUT)
        en_a_q <= i_bus.wdata[0];
      if (i_bus.addr == dppc_pkg::DPPC_OFS_P4_FUNC)
        pwm_q <= i_bus.wdata[0];
      if (i_bus.addr == dppc_pkg::DPPC_OFS_POWER)
        pwr_q <= i_bus.wdata[2:0];
    end
  end

  // Power mode classes
  assign run  = (pwr_q == dppc_pkg::DPPC_PWR_ACTIVE) || (pwr_q == dppc_pkg::DPPC_PWR_SUBACTIVE);
  assign park = (pwr_q == dppc_pkg::DPPC_PWR_STANDBY) || (pwr_q == dppc_pkg::DPPC_PWR_WATCH);
  assign nap  = (pwr_q == dppc_pkg::DPPC_PWR_SLEEP) || (pwr_q == dppc_pkg::DPPC_PWR_SUBSLEEP);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_rst_float: assert property ($fell(i_sys_rst) |-> o_p4.oe == 8'h00 && o_p6.oe == 8'h00)
    else $error("pins driven right after reset");
  a_read_idle: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_p4dir_ones: assert property (i_bus.rd && i_bus.addr == dppc_pkg::DPPC_OFS_P4_DIR |=> o_rdata == 8'hFF)
    else $error("first port direction read not all ones");
  a_p6dir_ones: assert property (i_bus.rd && i_bus.addr == dppc_pkg::DPPC_OFS_P6_DIR |=> o_rdata == 8'hFF)
    else $error("second port direction read not all ones");
  a_aux_low: assert property (i_bus.rd && i_bus.addr == dppc_pkg::DPPC_OFS_P6_AUX |=> o_rdata[5:0] == 6'h3F)
    else $error("aux unused bits not ones");
  a_edge_high: assert property (i_bus.rd && i_bus.addr == dppc_pkg::DPPC_OFS_RT_EDGE |=> o_rdata[7:2] == 6'h3F)
    else $error("edge reserved bits not ones");
  a_capture_follow: assert property ($stable(i_p4_pin) [*7] |-> o_periph.capture_in == i_p4_pin[4:1])
    else $error("capture inputs do not follow pins");
  a_cmp_a_drive: assert property (run && en_a_q ##1 run |-> o_p4.oe[5] && o_p4.out[5] == $past(i_periph.compare_out_a))
    else $error("compare A not on its pin");
  a_pwm_drive: assert property (run && pwm_q ##1 run |-> o_p4.oe[0] && o_p4.out[0] == $past(i_periph.wide_pwm_out))
    else $error("pwm not on its pin");
  a_standby_float: assert property (park ##1 park |-> o_p4.oe == 8'h00 && o_p6.oe == 8'h00)
    else $error("pins driven in standby or watch");
  a_sleep_hold: assert property (nap ##1 nap |-> $stable(o_p4) && $stable(o_p6))
    else $error("pins moved in sleep");
endmodule

/* bench/dppc_pin_world.sv */
// Outside world of both ports: resolves each pad from device and board drive
`timescale 1ns/1ps
module dppc_pin_world (
  input  wire dppc_pkg::dppc_pin_drive_t i_p4,
  input  wire dppc_pkg::dppc_pin_drive_t i_p6,
  input  wire logic [7:0]                i_ext4,
  input  wire logic [7:0]                i_ext6,
  output logic [7:0]                     o_p4_pin,
  output logic [7:0]                     o_p6_pin
);
  // Board holds a firm level wherever the device lets go, never mid-rail
  assign o_p4_pin = (i_p4.oe & i_p4.out) | (~i_p4.oe & i_ext4);
  assign o_p6_pin = (i_p6.oe & i_p6.out) | (~i_p6.oe & i_ext6);
endmodule

/* bench/tb_dppc_top.sv */
// Self-checking testbench for the dual port pin control block
`timescale 1ns/1ps
module tb_dppc_top;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  dppc_pkg::dppc_bus_req_t    bus = '0;
  dppc_pkg::dppc_periph_in_t  pin_in = '0;
  dppc_pkg::dppc_periph_out_t pout;
  dppc_pkg::dppc_pin_drive_t  p4;
  dppc_pkg::dppc_pin_drive_t  p6;
  logic [7:0]                 rdata;
  logic [7:0]                 p4_pin;
  logic [7:0]                 p6_pin;
  logic [7:0]                 ext4 = 8'h96;
  logic [7:0]                 ext6 = 8'h3C;
  int                         err_total = 0;
  int                         comparisons = 0;
  logic [15:0]                ra [9] = '{16'hFFC6, 16'hFFD6, 16'hFFD9, 16'hFFDD, 16'hFFE4, 16'hFFE5,
                                         16'hFFC4, 16'hFFD4, 16'hFFC0};
  logic [7:0]                 rv [9] = '{8'h3C, 8'hFF, 8'h3F, 8'h00, 8'hFC, 8'h00, 8'h96, 8'hFF, 8'h00};
  logic [2:0]                 pm [7] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h5, 3'h3, 3'h0};
  logic [7:0]                 pd [7] = '{8'h0F, 8'h0F, 8'h0F, 8'hF0, 8'h0F, 8'h0F, 8'h0F};
  logic [7:0]                 po [7] = '{8'hF0, 8'h0F, 8'h00, 8'hF0, 8'hF0, 8'h00, 8'h0F};

  always #10 clk = ~clk;

  dppc_top uut (.i_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_rdata(rdata), .i_periph(pin_in),
    .o_periph(pout), .i_p4_pin(p4_pin), .o_p4(p4), .i_p6_pin(p6_pin), .o_p6(p6));
  dppc_pin_world world (.i_p4(p4), .i_p6(p6), .i_ext4(ext4), .i_ext6(ext6), .o_p4_pin(p4_pin),
    .o_p6_pin(p6_pin));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk8(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk8($sformatf("read %h", a), rdata, exp);
  endtask

  // Long enough for the pin synchronisers and the drive register
  task automatic settle;
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Realtime step: edge, data, direction, trigger and head-switch levels
  task automatic rt_step(input logic [7:0] e, d, c, input logic p, h, input logic [7:0] xoe, xout);
    wr(dppc_pkg::DPPC_OFS_RT_EDGE, e);
    wr(dppc_pkg::DPPC_OFS_P6_DATA, d);
    wr(dppc_pkg::DPPC_OFS_P6_DIR, c);
    @(posedge clk);
    ext4[7] <= p;
    pin_in.head_switch_timing <= h;
    settle();
    chk8("rt oe", p6.oe, xoe);
    chk8("rt out", p6.out & xoe, xout);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk8("p4 oe", p4.oe, 8'h00);
    chk8("p6 oe", p6.oe, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rd_chk(ra[i], rv[i]);
    end
    wr(dppc_pkg::DPPC_OFS_P6_AUX, 8'h00);
    rd_chk(dppc_pkg::DPPC_OFS_P6_AUX, 8'h3F);
    wr(dppc_pkg::DPPC_OFS_RT_EDGE, 8'h00);
    rd_chk(dppc_pkg::DPPC_OFS_RT_EDGE, 8'hFC);
    wr(dppc_pkg::DPPC_OFS_P4_FUNC, 8'hFF);
    rd_chk(dppc_pkg::DPPC_OFS_P4_FUNC, 8'hFF);
    wr(dppc_pkg::DPPC_OFS_P4_FUNC, 8'h00);
    // Data register reset values show once every pin drives
    wr(dppc_pkg::DPPC_OFS_P4_DIR, 8'hFF);
    wr(dppc_pkg::DPPC_OFS_P6_DIR, 8'hFF);
    settle();
    rd_chk(dppc_pkg::DPPC_OFS_P4_DATA, 8'h00);
    rd_chk(dppc_pkg::DPPC_OFS_P6_DATA, 8'h00);
    chk8("p6 out", p6.out, 8'h00);
    // First port in general I/O, half in, half out
    wr(dppc_pkg::DPPC_OFS_P4_DIR, 8'h0F);
    wr(dppc_pkg::DPPC_OFS_P4_DATA, 8'hA5);
    settle();
    chk8("p4 oe", p4.oe, 8'h0F);
    chk8("p4 out", p4.out & 8'h0F, 8'h05);
    rd_chk(dppc_pkg::DPPC_OFS_P4_DATA, 8'h95);
    chk8("capture", {4'h0, pout.capture_in}, 8'h0A);
    // Compare outputs take their pins with direction at input
    pin_in.compare_out_a <= 1'b1;
    wr(dppc_pkg::DPPC_OFS_TIMER_OUT, 8'h03);
    settle();
    chk8("cmp oe", p4.oe, 8'h6F);
    chk8("cmp out", {6'h0, p4.out[6:5]}, 8'h01);
    pin_in.compare_out_a <= 1'b0;
    pin_in.compare_out_b <= 1'b1;
    settle();
    chk8("cmp out", {6'h0, p4.out[6:5]}, 8'h02);
    wr(dppc_pkg::DPPC_OFS_TIMER_OUT, 8'h00);
    // Trigger and pwm functions override direction and data
    wr(dppc_pkg::DPPC_OFS_P4_DIR, 8'h8F);
    wr(dppc_pkg::DPPC_OFS_P4_FUNC, 8'h81);
    settle();
    chk8("fn oe", p4.oe, 8'h0F);
    chk8("pwm out", {7'h0, p4.out[0]}, 8'h00);
    chk8("trig in", {7'h0, pout.realtime_trigger_in}, 8'h01);
    wr(dppc_pkg::DPPC_OFS_P4_FUNC, 8'h00);
    settle();
    chk8("gpio oe", p4.oe, 8'h8F);
    chk8("gpio out", p4.out & 8'h81, 8'h81);
    // Every power mode: float, hold or operate
    wr(dppc_pkg::DPPC_OFS_P4_DIR, 8'hF0);
    for (int i = 0; i < 7; i++) begin
      wr(dppc_pkg::DPPC_OFS_POWER, {5'h0, pm[i]});
      wr(dppc_pkg::DPPC_OFS_P4_DIR, pd[i]);
      settle();
      chk8("power oe", p4.oe, po[i]);
    end
    wr(dppc_pkg::DPPC_OFS_P4_DIR, 8'h00);
    // Second port in general I/O, then its event and converter pins
    wr(dppc_pkg::DPPC_OFS_P6_DIR, 8'h70);
    wr(dppc_pkg::DPPC_OFS_P6_DATA, 8'h5A);
    settle();
    chk8("p6 oe", p6.oe, 8'h70);
    chk8("p6 out", p6.out & 8'h70, 8'h50);
    rd_chk(dppc_pkg::DPPC_OFS_P6_DATA, 8'h5C);
    wr(dppc_pkg::DPPC_OFS_P6_AUX, 8'hC0);
    rd_chk(dppc_pkg::DPPC_OFS_P6_AUX, 8'hFF);
    settle();
    chk8("event", {5'h0, pout[2:0]}, 8'h03);
    @(posedge clk);
    ext6[7] <= 1'b1;
    settle();
    chk8("event", {5'h0, pout[2:0]}, 8'h07);
    wr(dppc_pkg::DPPC_OFS_P6_AUX, 8'h00);
    settle();
    chk8("event", {5'h0, pout[2:0]}, 8'h01);
    // Realtime mode: slaves keep the last general I/O values until a trigger
    wr(dppc_pkg::DPPC_OFS_P6_FUNC, 8'hFF);
    settle();
    chk8("rt oe", p6.oe, 8'h70);
    chk8("rt out", p6.out & 8'h70, 8'h50);
    rt_step(8'h01, 8'hC3, 8'h0F, 1'b0, 1'b0, 8'h70, 8'h50);
    rd_chk(dppc_pkg::DPPC_OFS_P6_DATA, 8'hC3);
    rt_step(8'h01, 8'hC3, 8'h0F, 1'b1, 1'b0, 8'h0F, 8'h03);
    rt_step(8'h02, 8'h3C, 8'hFF, 1'b0, 1'b0, 8'hFF, 8'h3C);
    rt_step(8'h00, 8'h11, 8'h00, 1'b1, 1'b0, 8'hFF, 8'h3C);
    rt_step(8'h03, 8'h11, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
    rt_step(8'h03, 8'h5A, 8'hFF, 1'b1, 1'b0, 8'hFF, 8'h5A);
    wr(dppc_pkg::DPPC_OFS_RT_SRC, 8'hFF);
    rt_step(8'h02, 8'hA5, 8'hFF, 1'b0, 1'b0, 8'hFF, 8'h5A);
    rt_step(8'h02, 8'hA5, 8'hFF, 1'b0, 1'b1, 8'hFF, 8'h5A);
    rt_step(8'h02, 8'hA5, 8'hFF, 1'b0, 1'b0, 8'hFF, 8'hA5);
    tally_and_finish();
  end

  // Watchdog: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule

bind dppc_top dppc_checker chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_periph(i_periph), .o_periph(o_periph), .i_p4_pin(i_p4_pin), .o_p4(o_p4), .o_p6(o_p6));
